// File: logic/cjm_pkg.sv
package cjm_pkg;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] WDOG_ADDR = 16'h0120;
  // The key value is arbitrary.
  localparam logic [7:0] WDOG_KEY = 8'ha5;
  localparam logic [2:0] JUMP_TAG = 3'h1;
  localparam logic [3:0] MOV_OP = 4'h4;
  localparam logic [8:0] PUSH_OP = 9'h024;
  localparam logic [2:0] COND_NZ = 3'h0;
  localparam logic [2:0] COND_Z = 3'h1;
  localparam logic [2:0] COND_NC = 3'h2;
  localparam logic [2:0] COND_C = 3'h3;
  localparam logic [2:0] COND_N = 3'h4;
  localparam logic [2:0] COND_GE = 3'h5;
  localparam logic [2:0] COND_L = 3'h6;
  localparam logic [2:0] COND_ALWAYS = 3'h7;
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 8;
  localparam logic [1:0] AS_REG = 2'h0;
  localparam logic [1:0] AS_IDX = 2'h1;
  localparam logic [1:0] AS_IND = 2'h2;
  localparam logic [1:0] AS_INC = 2'h3;
  localparam logic [15:0] CG_0 = 16'h0000;
  localparam logic [15:0] CG_1 = 16'h0001;
  localparam logic [15:0] CG_2 = 16'h0002;
  localparam logic [15:0] CG_4 = 16'h0004;
  localparam logic [15:0] CG_8 = 16'h0008;
  localparam logic [15:0] CG_ALL = 16'hffff;
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_REG_SEL = 8'h08;
  localparam logic [7:0] OFF_REG_DATA = 8'h0c;
  localparam int CTRL_RUN = 0;
  localparam int STAT_HALTED = 0;
  localparam int STAT_WDOG = 1;
  localparam int STAT_BADOP = 2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_JUMP, ST_SRC_EXT, ST_SRC_READ, ST_DST_REG,
    ST_DST_EXT, ST_DST_CALC, ST_DST_WRITE, ST_PUSH_DEC
  } cjm_state_t;
endpackage

// File: logic/cjm_ifs.sv
`timescale 1ns/1ps
interface cjm_rf_if;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [15:0] wr_data;
  logic [3:0] a_idx, b_idx, c_idx;
  logic [15:0] a_data, b_data, c_data, sp, sr;
  modport core (output wr_en, wr_idx, wr_data, a_idx, b_idx, c_idx,
                input a_data, b_data, c_data, sp, sr);
  modport store (input wr_en, wr_idx, wr_data, a_idx, b_idx, c_idx,
                 output a_data, b_data, c_data, sp, sr);
endinterface

interface cjm_br_if;
  logic [2:0] cond;
  logic [9:0] offset;
  logic [15:0] pc, sr, target;
  logic taken;
  modport core (output cond, offset, pc, sr, input taken, target);
  modport unit (input cond, offset, pc, sr, output taken, target);
endinterface

// File: logic/cjm_regfile.sv
`timescale 1ns/1ps
module cjm_regfile (
  input wire logic clk,
  input wire logic rst,
  cjm_rf_if.store rf
);
  logic [15:0] regs [1:15];

  // The program counter lives in the core and the constant register holds nothing.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 1; i < 16; i++)
        regs[i] <= cjm_pkg::RESET_WORD;
    end
    else if (rf.wr_en && rf.wr_idx != cjm_pkg::REG_PC && rf.wr_idx != cjm_pkg::REG_CG)
      regs[rf.wr_idx] <= rf.wr_data;
  end

  function automatic logic [15:0] rd(input logic [3:0] idx);
    if (idx == cjm_pkg::REG_PC || idx == cjm_pkg::REG_CG)
      return cjm_pkg::RESET_WORD;
    return regs[idx];
  endfunction

  assign rf.a_data = rd(rf.a_idx);
  assign rf.b_data = rd(rf.b_idx);
  assign rf.c_data = rd(rf.c_idx);
  assign rf.sp = regs[cjm_pkg::REG_SP];
  assign rf.sr = regs[cjm_pkg::REG_SR];
endmodule

// File: logic/cjm_branch.sv
`timescale 1ns/1ps
module cjm_branch (
  cjm_br_if.unit br
);
  always_comb
  begin
    case (br.cond)
      cjm_pkg::COND_NZ: br.taken = !br.sr[cjm_pkg::SR_Z]; // RL2
      cjm_pkg::COND_Z: br.taken = br.sr[cjm_pkg::SR_Z]; // RL1
      cjm_pkg::COND_NC: br.taken = !br.sr[cjm_pkg::SR_C]; // RL6
      cjm_pkg::COND_C: br.taken = br.sr[cjm_pkg::SR_C];
      cjm_pkg::COND_N: br.taken = br.sr[cjm_pkg::SR_N]; // RL5
      cjm_pkg::COND_GE: br.taken = !(br.sr[cjm_pkg::SR_N] ^ br.sr[cjm_pkg::SR_V]); // RL3
      cjm_pkg::COND_L: br.taken = br.sr[cjm_pkg::SR_N] ^ br.sr[cjm_pkg::SR_V]; // RL4
      cjm_pkg::COND_ALWAYS: br.taken = 1'b1; // RL7
      default: br.taken = 1'b0;
    endcase
  end

  // The pc given here is already past the jump word, so reach is -511..+512 words.
  assign br.target = br.pc + {{5{br.offset[9]}}, br.offset, 1'b0}; // RL1 RL7 RL8 RL19
endmodule

// File: logic/cjm_exec.sv
`timescale 1ns/1ps
// Functional notes
// RL1: Zero-flag jump adds twice the signed 10-bit offset when zero is set.
// RL2: Not-zero jump is taken when the zero flag is clear.
// RL3: Signed greater-or-equal jump is taken when negative equals overflow.
// RL4: Signed less jump is taken when negative differs from overflow.
// RL5: Negative jump is taken when the negative flag is set.
// RL6: No-carry jump is taken when carry is clear, for unsigned compares.
// RL7: The unconditional jump always adds twice the signed offset.
// RL8: Unconditional jump reaches -511 to +512 words from the program counter.
// RL9: Jumps, moves, pops and pushes never change the arithmetic flags.
// RL10: Moves and pushes keep crystal stop, core halt and interrupt enable.
// RL11: Copy writes the source into the destination, source left intact.
// RL12: Pop reads top word to a temporary, bumps the pointer, then writes.
// RL13: Byte pop still advances the stack pointer by two.
// RL14: Byte pop to a register zeroes the register's high byte.
// RL15: Push lowers the stack pointer by two, then stores at the new top.
// RL16: Byte push still lowers the stack pointer by two.
// RL17: Idle emulations cost 1, 6, 5 and 2 cycles as specified.
// RL18: A write to the watchdog word without its key flags a violation.
// RL19: Jump offsets add to the address of the jump plus two.
module cjm_exec (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic [1:0] MEM_WE,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  output logic HALTED,
  output logic WDOG_VIOLATION
);
  cjm_rf_if rf ();
  cjm_br_if br ();
  cjm_pkg::cjm_state_t state, next_state;
  logic [15:0] pc, next_pc, ir, ext, next_ext, tmp, next_tmp, next_addr, next_wdata;
  logic [15:0] op, pc_inc, src_val, src_sized, mem_byte, rd_val, base_src, base_dst;
  logic [15:0] step, new_sp;
  logic [31:0] rdata_mux;
  logic [1:0] next_we, as_mode, lane;
  logic [3:0] src_idx, dst_idx, reg_sel;
  logic [7:0] dp_addr;
  logic next_rd, run, badop, badop_set, wdog_hit, to_fetch, dp_write;
  logic is_jump, is_mov, is_push, byte_op, ad, src_cg, src_direct, bus_rf_wr;

  cjm_regfile i_cjm_regfile (.clk(REF_CLK), .rst(RESET), .rf(rf));
  cjm_branch i_cjm_branch (.br(br));

  // Decode reads the word straight off the bus during fetch, the latched word after.
  assign op = (state == cjm_pkg::ST_FETCH) ? MEM_RDATA : ir;
  assign is_jump = op[15:13] == cjm_pkg::JUMP_TAG;
  assign is_mov = op[15:12] == cjm_pkg::MOV_OP;
  assign is_push = op[15:7] == cjm_pkg::PUSH_OP;
  assign byte_op = op[6];
  assign as_mode = op[5:4];
  assign ad = op[7];
  assign src_idx = is_push ? op[3:0] : op[11:8];
  assign dst_idx = op[3:0];
  assign pc_inc = pc + cjm_pkg::WORD_STEP;
  assign src_cg = (src_idx == cjm_pkg::REG_SR && as_mode[1]) || src_idx == cjm_pkg::REG_CG;
  assign src_direct = src_cg || as_mode == cjm_pkg::AS_REG;
  assign rf.a_idx = src_idx;
  assign rf.b_idx = dst_idx;
  assign rf.c_idx = reg_sel;
  assign br.cond = op[12:10];
  assign br.offset = op[9:0];
  assign br.pc = pc;
  assign br.sr = rf.sr;

  always_comb
  begin
    src_val = (src_idx == cjm_pkg::REG_PC) ? pc_inc : rf.a_data;
    if (src_idx == cjm_pkg::REG_CG)
    begin
      case (as_mode)
        cjm_pkg::AS_REG: src_val = cjm_pkg::CG_0;
        cjm_pkg::AS_IDX: src_val = cjm_pkg::CG_1;
        cjm_pkg::AS_IND: src_val = cjm_pkg::CG_2;
        default: src_val = cjm_pkg::CG_ALL;
      endcase
    end
    else if (src_cg)
      src_val = (as_mode == cjm_pkg::AS_IND) ? cjm_pkg::CG_4 : cjm_pkg::CG_8;
  end

  assign src_sized = byte_op ? {8'h00, src_val[7:0]} : src_val; // RL14
  assign mem_byte = MEM_ADDR[0] ? {8'h00, MEM_RDATA[15:8]} : {8'h00, MEM_RDATA[7:0]};
  assign rd_val = byte_op ? mem_byte : MEM_RDATA;
  assign base_src = (src_idx == cjm_pkg::REG_PC) ? MEM_ADDR :
                    (src_idx == cjm_pkg::REG_SR) ? cjm_pkg::RESET_WORD : rf.a_data;
  assign base_dst = (dst_idx == cjm_pkg::REG_PC) ? MEM_ADDR :
                    (dst_idx == cjm_pkg::REG_SR) ? cjm_pkg::RESET_WORD : rf.b_data;
  // The stack and program pointers stay word aligned even for byte operands.
  assign step = (!byte_op || src_idx == cjm_pkg::REG_SP || src_idx == cjm_pkg::REG_PC) ?
                cjm_pkg::WORD_STEP : cjm_pkg::BYTE_STEP; // RL13
  assign new_sp = rf.sp - cjm_pkg::STACK_STEP; // RL15 RL16
  assign lane = ext[0] ? cjm_pkg::LANE_HI : cjm_pkg::LANE_LO;
  assign bus_rf_wr = dp_write && dp_addr == cjm_pkg::OFF_REG_DATA && state == cjm_pkg::ST_IDLE;

  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_ext = ext;
    next_tmp = tmp;
    next_addr = MEM_ADDR;
    next_rd = 1'b0;
    next_we = cjm_pkg::LANE_NONE;
    next_wdata = MEM_WDATA;
    rf.wr_en = 1'b0;
    rf.wr_idx = dst_idx;
    rf.wr_data = tmp;
    badop_set = 1'b0;
    to_fetch = 1'b0;
    case (state)
      cjm_pkg::ST_IDLE:
      begin
        if (bus_rf_wr && reg_sel == cjm_pkg::REG_PC)
          next_pc = HWDATA[15:0];
        rf.wr_en = bus_rf_wr;
        rf.wr_idx = reg_sel;
        rf.wr_data = HWDATA[15:0];
        to_fetch = 1'b1;
      end
      cjm_pkg::ST_FETCH:
      begin
        next_pc = pc_inc;
        if (is_jump)
          next_state = cjm_pkg::ST_JUMP; // RL17
        else if (!is_mov && !is_push)
        begin
          badop_set = 1'b1;
          to_fetch = 1'b1;
        end
        else if (!src_direct && as_mode == cjm_pkg::AS_IDX)
        begin
          next_state = cjm_pkg::ST_SRC_EXT;
          next_addr = pc_inc;
          next_rd = 1'b1;
        end
        else if (!src_direct)
        begin
          next_state = cjm_pkg::ST_SRC_READ;
          next_addr = (src_idx == cjm_pkg::REG_PC) ? pc_inc : rf.a_data;
          next_rd = 1'b1;
        end
        else
        begin
          next_tmp = src_sized;
          if (is_push)
            next_state = cjm_pkg::ST_PUSH_DEC;
          else if (ad)
          begin
            next_state = cjm_pkg::ST_DST_EXT;
            next_addr = pc_inc;
            next_rd = 1'b1;
          end
          else
          begin
            // Register to register copy finishes in the fetch cycle itself.
            if (dst_idx == cjm_pkg::REG_PC)
              next_pc = src_sized;
            rf.wr_en = dst_idx != cjm_pkg::REG_PC; // RL11 RL17
            rf.wr_data = src_sized;
            to_fetch = 1'b1;
          end
        end
      end
      cjm_pkg::ST_SRC_EXT:
      begin
        next_pc = pc_inc;
        next_addr = base_src + MEM_RDATA;
        next_rd = 1'b1;
        next_state = cjm_pkg::ST_SRC_READ;
      end
      cjm_pkg::ST_SRC_READ:
      begin
        next_tmp = rd_val; // RL12
        if (as_mode == cjm_pkg::AS_INC && src_idx == cjm_pkg::REG_PC)
          next_pc = pc + step;
        rf.wr_en = as_mode == cjm_pkg::AS_INC && src_idx != cjm_pkg::REG_PC; // RL12
        rf.wr_idx = src_idx;
        rf.wr_data = rf.a_data + step; // RL12 RL13
        if (is_push)
          next_state = cjm_pkg::ST_PUSH_DEC;
        else if (ad)
        begin
          next_state = cjm_pkg::ST_DST_EXT;
          next_addr = next_pc;
          next_rd = 1'b1;
        end
        else
          next_state = cjm_pkg::ST_DST_REG;
      end
      cjm_pkg::ST_DST_REG:
      begin
        // Only an explicit move into the status word touches its flags and mode bits.
        if (dst_idx == cjm_pkg::REG_PC)
          next_pc = tmp;
        rf.wr_en = dst_idx != cjm_pkg::REG_PC; // RL9 RL10 RL11 RL14
        to_fetch = 1'b1;
      end
      cjm_pkg::ST_DST_EXT:
      begin
        next_pc = pc_inc;
        next_ext = base_dst + MEM_RDATA;
        next_state = cjm_pkg::ST_DST_CALC;
      end
      cjm_pkg::ST_DST_CALC:
      begin
        next_addr = ext;
        next_we = byte_op ? lane : cjm_pkg::LANE_BOTH;
        next_wdata = byte_op ? {tmp[7:0], tmp[7:0]} : tmp; // RL11
        next_state = cjm_pkg::ST_DST_WRITE; // RL17
      end
      cjm_pkg::ST_PUSH_DEC:
      begin
        rf.wr_en = 1'b1; // RL15 RL16
        rf.wr_idx = cjm_pkg::REG_SP;
        rf.wr_data = new_sp;
        next_addr = new_sp; // RL15
        next_we = byte_op ? cjm_pkg::LANE_LO : cjm_pkg::LANE_BOTH;
        next_wdata = byte_op ? {tmp[7:0], tmp[7:0]} : tmp;
        next_state = cjm_pkg::ST_DST_WRITE;
      end
      cjm_pkg::ST_DST_WRITE:
        to_fetch = 1'b1;
      cjm_pkg::ST_JUMP:
      begin
        if (br.taken)
          next_pc = br.target; // RL1 RL2 RL3 RL4 RL5 RL6 RL7
        to_fetch = 1'b1; // RL17
      end
      default:
        next_state = cjm_pkg::ST_IDLE;
    endcase
    if (to_fetch)
    begin
      next_state = run ? cjm_pkg::ST_FETCH : cjm_pkg::ST_IDLE;
      next_addr = next_pc;
      next_rd = run;
      next_we = cjm_pkg::LANE_NONE;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state <= cjm_pkg::ST_IDLE;
      pc <= cjm_pkg::RESET_PC;
      ir <= cjm_pkg::RESET_WORD;
      ext <= cjm_pkg::RESET_WORD;
      tmp <= cjm_pkg::RESET_WORD;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      ext <= next_ext;
      tmp <= next_tmp;
      if (state == cjm_pkg::ST_FETCH)
        ir <= MEM_RDATA;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      MEM_ADDR <= cjm_pkg::RESET_PC;
      MEM_RD <= 1'b0;
      MEM_WE <= cjm_pkg::LANE_NONE;
      MEM_WDATA <= cjm_pkg::RESET_WORD;
    end
    else
    begin
      MEM_ADDR <= next_addr;
      MEM_RD <= next_rd;
      MEM_WE <= next_we;
      MEM_WDATA <= next_wdata;
    end
  end

  // A byte write can never carry the key, so it is a violation as well.
  assign wdog_hit = MEM_WE != cjm_pkg::LANE_NONE && MEM_ADDR[15:1] == cjm_pkg::WDOG_ADDR[15:1] &&
                    (MEM_WE != cjm_pkg::LANE_BOTH || MEM_WDATA[15:8] != cjm_pkg::WDOG_KEY); // RL18

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      WDOG_VIOLATION <= 1'b0;
    else if (wdog_hit)
      WDOG_VIOLATION <= 1'b1; // RL18
    else if (dp_write && dp_addr == cjm_pkg::OFF_STATUS && HWDATA[cjm_pkg::STAT_WDOG])
      WDOG_VIOLATION <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      badop <= 1'b0;
    else if (badop_set)
      badop <= 1'b1;
    else if (dp_write && dp_addr == cjm_pkg::OFF_STATUS && HWDATA[cjm_pkg::STAT_BADOP])
      badop <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      run <= 1'b0;
      reg_sel <= cjm_pkg::REG_PC;
    end
    else if (dp_write && dp_addr == cjm_pkg::OFF_CTRL)
      run <= HWDATA[cjm_pkg::CTRL_RUN];
    else if (dp_write && dp_addr == cjm_pkg::OFF_REG_SEL)
      reg_sel <= HWDATA[3:0];
  end

  always_comb
  begin
    rdata_mux = 32'h00000000;
    case (HADDR[7:0])
      cjm_pkg::OFF_CTRL: rdata_mux[cjm_pkg::CTRL_RUN] = run;
      cjm_pkg::OFF_STATUS:
      begin
        rdata_mux[cjm_pkg::STAT_HALTED] = state == cjm_pkg::ST_IDLE;
        rdata_mux[cjm_pkg::STAT_WDOG] = WDOG_VIOLATION;
        rdata_mux[cjm_pkg::STAT_BADOP] = badop;
      end
      cjm_pkg::OFF_REG_SEL: rdata_mux[3:0] = reg_sel;
      cjm_pkg::OFF_REG_DATA: rdata_mux[15:0] = (reg_sel == cjm_pkg::REG_PC) ? pc : rf.c_data;
      default: rdata_mux = 32'h00000000;
    endcase
  end

  // Zero wait state slave: read data are captured at the address phase edge.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      dp_write <= 1'b0;
      dp_addr <= cjm_pkg::OFF_CTRL;
      HRDATA <= 32'h00000000;
    end
    else if (HREADY)
    begin
      dp_write <= HSEL && HTRANS[1] && HWRITE;
      dp_addr <= HADDR[7:0];
      HRDATA <= (HSEL && HTRANS[1] && !HWRITE) ? rdata_mux : 32'h00000000;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HALTED = state == cjm_pkg::ST_IDLE;
endmodule

// File: bench/cjm_exec_checker.sv
`timescale 1ns/1ps
module cjm_exec_checker (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic [1:0] MEM_WE,
  input wire logic [15:0] MEM_WDATA,
  input wire logic HALTED,
  input wire logic WDOG_VIOLATION
);
  logic rd_ph;
  logic key_miss;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // Either byte of the watchdog word counts, and only a full word with the key is safe.
  assign key_miss = MEM_WE != 2'h0 && MEM_ADDR[15:1] == cjm_pkg::WDOG_ADDR[15:1]
    && (MEM_WE != 2'h3 || MEM_WDATA[15:8] != cjm_pkg::WDOG_KEY);
  always_ff @(posedge REF_CLK)
  begin
    rd_ph <= !RESET && HSEL && HREADY && HTRANS[1] && !HWRITE;
  end
  chk_wdog_miss: assert property (key_miss |=> WDOG_VIOLATION)
    else $error("watchdog violation not raised");
  chk_wdog_cause: assert property ($rose(WDOG_VIOLATION) |-> $past(key_miss))
    else $error("watchdog violation without a keyless write");
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus response not ready and okay");
  chk_rdata_idle: assert property (!rd_ph |-> HRDATA == 32'h0)
    else $error("read data outside a read data phase");
  chk_rdata_upper: assert property (rd_ph |-> HRDATA[31:16] == 16'h0)
    else $error("upper read data bits not zero");
  chk_wr_no_rd: assert property (MEM_WE != 2'h0 |-> !MEM_RD)
    else $error("memory read during a write cycle");
  chk_wr_single: assert property (MEM_WE != 2'h0 |=> MEM_WE == 2'h0)
    else $error("memory write longer than one cycle");
  chk_halt_quiet: assert property (HALTED |-> !MEM_RD && MEM_WE == 2'h0)
    else $error("memory access while halted");
endmodule
bind cjm_exec cjm_exec_checker i_cjm_exec_checker (.REF_CLK, .RESET, .HSEL, .HTRANS, .HWRITE,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MEM_ADDR, .MEM_RD, .MEM_WE, .MEM_WDATA, .HALTED,
  .WDOG_VIOLATION);

// File: bench/cjm_mem_model.sv
`timescale 1ns/1ps
module cjm_mem_model (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic [1:0] we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] last;
  // Outside a read the port shows the inverse of its last word, so late sampling is caught.
  assign rdata = rd ? mem[addr[15:1]] : ~last;
  // Every word starts as a jump to itself, so any stray fetch parks the core.
  initial
  begin
    last = 16'h0000;
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'h3fff;
  end
  always @(posedge clk)
  begin
    if (rd)
      last <= mem[addr[15:1]];
    if (we[0])
      mem[addr[15:1]][7:0] <= wdata[7:0];
    if (we[1])
      mem[addr[15:1]][15:8] <= wdata[15:8];
  end
endmodule

// File: bench/cjm_exec_bench.sv
`timescale 1ns/1ps
module cjm_exec_bench;
  logic REF_CLK, RESET, HSEL, HWRITE, MEM_RD, HALTED, WDOG_VIOLATION, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rv;
  logic [1:0] HTRANS, MEM_WE;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, exp_pc;
  int n_fail, n_tests, cyc;
  logic [15:0] srs [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h0104};
  logic [9:0] offs [3] = '{10'h200, 10'h1ff, 10'h000};
  logic [15:0] cp_op [3] = '{16'h4303, 16'h4494, 16'h44a4};
  logic [15:0] cp_nx [3] = '{16'h0002, 16'h0006, 16'h0004};
  logic [31:0] cp_cy [3] = '{32'h1, 32'h6, 32'h5};
  logic cp_wd [3] = '{1'b0, 1'b1, 1'b1};
  cjm_exec i_cjm_exec (.REF_CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .MEM_ADDR, .MEM_RD, .MEM_WE, .MEM_WDATA,
    .MEM_RDATA, .HALTED, .WDOG_VIOLATION);
  cjm_mem_model i_cjm_mem_model (.clk(REF_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .we(MEM_WE),
    .wdata(MEM_WDATA), .rdata(MEM_RDATA));
  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  task automatic summarize();
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 60)
    begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      guard(n);
    end
    while (HREADYOUT !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    edge_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    edge_ready();
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rv);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask
  task automatic setr(input logic [3:0] i, input logic [15:0] v);
    wr(cjm_pkg::OFF_REG_SEL, {28'h0, i});
    wr(cjm_pkg::OFF_REG_DATA, {16'h0, v});
  endtask
  task automatic getr(input logic [3:0] i, output logic [31:0] r);
    wr(cjm_pkg::OFF_REG_SEL, {28'h0, i});
    rd(cjm_pkg::OFF_REG_DATA, r);
  endtask
  task automatic memw(input logic [15:0] a, input logic [15:0] v);
    i_cjm_mem_model.mem[a[15:1]] = v;
  endtask
  task automatic wait_fetch(input logic [15:0] a, output int n);
    n = 0;
    do
    begin
      @(negedge REF_CLK);
      guard(n);
    end
    while (!(MEM_RD === 1'b1 && MEM_ADDR === a));
  endtask
  // Runs from pc until the fetch at pc_end, then halts and checks the flags survived.
  task automatic exec(input logic [15:0] pc, input logic [15:0] sr, input logic [15:0] pc_end,
                      output int c);
    int n;
    setr(cjm_pkg::REG_PC, pc);
    setr(cjm_pkg::REG_SR, sr);
    wr(cjm_pkg::OFF_CTRL, 32'h1);
    wait_fetch(pc, n);
    wait_fetch(pc_end, c);
    @(posedge REF_CLK);
    wr(cjm_pkg::OFF_CTRL, 32'h0);
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      guard(n);
    end
    while (HALTED !== 1'b1);
    getr(cjm_pkg::REG_SR, rv);
    chk(rv, {16'h0, sr});
  endtask
  function automatic logic taken(input logic [2:0] c, input logic [15:0] s);
    logic n_v;
    n_v = s[cjm_pkg::SR_N] ^ s[cjm_pkg::SR_V];
    case (c)
      cjm_pkg::COND_NZ: taken = !s[cjm_pkg::SR_Z];
      cjm_pkg::COND_Z: taken = s[cjm_pkg::SR_Z];
      cjm_pkg::COND_NC: taken = !s[cjm_pkg::SR_C];
      cjm_pkg::COND_C: taken = s[cjm_pkg::SR_C];
      cjm_pkg::COND_N: taken = s[cjm_pkg::SR_N];
      cjm_pkg::COND_GE: taken = !n_v;
      cjm_pkg::COND_L: taken = n_v;
      default: taken = 1'b1;
    endcase
  endfunction
  initial
  begin
    RESET = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    rd(cjm_pkg::OFF_CTRL, rv);
    chk(rv, 32'h0);
    rd(cjm_pkg::OFF_STATUS, rv);
    chk(rv, 32'h1);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, rv);
    chk(rv, 32'h0);
    // A taken jump lands on 0x6 and a fall-through on 0x2; both words are self-loops.
    for (int c = 0; c < 8; c++)
      for (int k = 0; k < 6; k++)
      begin
        exp_pc = taken(c[2:0], srs[k]) ? 16'h0006 : 16'h0002;
        memw(16'h0000, {cjm_pkg::JUMP_TAG, c[2:0], 10'h002});
        exec(16'h0000, srs[k], exp_pc, cyc);
        chk(32'(cyc), 32'h2);
      end
    for (int k = 0; k < 3; k++)
    begin
      exp_pc = 16'h0802 + {{5{offs[k][9]}}, offs[k], 1'b0};
      memw(16'h0800, {cjm_pkg::JUMP_TAG, cjm_pkg::COND_ALWAYS, offs[k]});
      exec(16'h0800, 16'h0000, exp_pc, cyc);
      getr(cjm_pkg::REG_PC, rv);
      chk(rv, {16'h0, exp_pc});
    end
    setr(4'h4, 16'h0120);
    for (int k = 0; k < 3; k++)
    begin
      memw(16'h0000, cp_op[k]);
      memw(16'h0002, 16'h0000);
      memw(16'h0004, 16'h0000);
      memw(cp_nx[k], 16'h3fff);
      exec(16'h0000, 16'h013f, cp_nx[k], cyc);
      chk(32'(cyc), cp_cy[k]);
      rd(cjm_pkg::OFF_STATUS, rv);
      chk(rv, {30'h0, cp_wd[k], 1'b1});
      wr(cjm_pkg::OFF_STATUS, 32'h2);
    end
    rd(cjm_pkg::OFF_STATUS, rv);
    chk(rv, 32'h1);
    setr(4'h5, 16'h8123);
    setr(4'h4, 16'h0301);
    memw(16'h0002, 16'h3fff);
    memw(16'h0000, 16'h4506);
    exec(16'h0000, 16'h0107, 16'h0002, cyc);
    getr(4'h6, rv);
    chk(rv, 32'h8123);
    memw(16'h0000, 16'h45c4);
    memw(16'h0002, 16'h0000);
    memw(16'h0004, 16'h3fff);
    exec(16'h0000, 16'h0107, 16'h0004, cyc);
    chk({16'h0, i_cjm_mem_model.mem[15'h0180]}, 32'h23ff);
    getr(4'h5, rv);
    chk(rv, 32'h8123);
    memw(16'h0002, 16'h3fff);
    for (int b = 0; b < 2; b++)
    begin
      memw(16'h0400, 16'hbeef);
      setr(cjm_pkg::REG_SP, 16'h0400);
      memw(16'h0000, {4'h4, 4'h1, 1'b0, b[0], cjm_pkg::AS_INC, 4'h7});
      exec(16'h0000, 16'h0107, 16'h0002, cyc);
      getr(4'h7, rv);
      chk(rv, b ? 32'h00ef : 32'hbeef);
      getr(cjm_pkg::REG_SP, rv);
      chk(rv, 32'h0402);
      memw(16'h0000, {cjm_pkg::PUSH_OP, b[0], cjm_pkg::AS_REG, 4'h5});
      exec(16'h0000, 16'h013f, 16'h0002, cyc);
      getr(cjm_pkg::REG_SP, rv);
      chk(rv, 32'h0400);
      chk({16'h0, i_cjm_mem_model.mem[15'h0200]}, b ? 32'hbe23 : 32'h8123);
    end
    memw(16'h0000, 16'h4338);
    exec(16'h0000, 16'h013f, 16'h0002, cyc);
    chk(32'(cyc), 32'h1);
    getr(4'h8, rv);
    chk(rv, 32'hffff);
    memw(16'h0000, 16'h4039);
    memw(16'h0002, 16'h1234);
    memw(16'h0004, 16'h3fff);
    exec(16'h0000, 16'h013f, 16'h0004, cyc);
    getr(4'h9, rv);
    chk(rv, 32'h1234);
    summarize();
  end
endmodule
